// ### pkg/hsg_pkg.sv
// Package: constants for the header simple GPIO block
package hsg_pkg;
  // ---------------------------------------------------------------------------
  // Bus widths
  // ---------------------------------------------------------------------------
  localparam int HSG_ADDR_W = 32;
  localparam int HSG_DATA_W = 32;
  localparam int HSG_PINS = 8;

  // ---------------------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------------------
  localparam logic [31:0] HSG_GPIO_BASE = 32'h12C0_0000;
  localparam logic [31:0] HSG_LEVEL_IDX = 32'h0000_0000;
  localparam logic [31:0] HSG_DIR_IDX = 32'h0000_0001;
  // Indices are word numbers; byte offset from the base is four times the index
  localparam logic [31:0] HSG_LEVEL_ADDR = HSG_GPIO_BASE + (HSG_LEVEL_IDX << 2);
  localparam logic [31:0] HSG_DIR_ADDR = HSG_GPIO_BASE + (HSG_DIR_IDX << 2);
  localparam logic [31:0] HSG_EXTRA_ADDR = 32'h2140_0000;

  // ---------------------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------------------
  localparam int HSG_EXTRA_DIR_BIT = 1;
  localparam int HSG_EXTRA_DATA_BIT = 2;
  localparam logic [7:0] HSG_LEVEL_RST = 8'h00;
  localparam logic [7:0] HSG_DIR_RST = 8'h00;
  localparam logic [7:0] HSG_EXTRA_RST = 8'h00;
  // Header bits taken over by the extra serial ports when fitted
  localparam int HSG_A_TXD_BIT = 2;
  localparam int HSG_A_RXD_BIT = 3;
  localparam int HSG_B_TXD_BIT = 4;
  localparam int HSG_B_RXD_BIT = 5;
  localparam int HSG_A_FRAME_BIT = 6;
  localparam int HSG_B_FRAME_BIT = 7;
  localparam logic [7:0] HSG_SERIAL_MASK = 8'hFC;
  localparam logic [7:0] HSG_SERIAL_OUT_MASK = 8'hD4;

  // ---------------------------------------------------------------------------
  // AXI responses
  // ---------------------------------------------------------------------------
  localparam logic [1:0] HSG_RESP_OKAY = 2'h0;
  localparam logic [1:0] HSG_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    HSG_REG_LEVEL = 3'b001,
    HSG_REG_DIR = 3'b010,
    HSG_REG_EXTRA = 3'b100
  } hsg_reg_sel_t;
endpackage : hsg_pkg

// ### design/hsg_gpio.sv
// Design: header simple GPIO block with AXI4-Lite register slave
// Function
// [R1] Without the serial option, header pins act as plain GPIO pins.
// [R2] With the serial option fitted, header pins carry the two extra serial ports.
// [R3] Level register at word index 0, direction at index 1, from the base address.
// [R4] Level bit one drives pin high, zero drives pin low.
// [R5] Direction bit one makes the pin output, zero input.
// [R6] Bit X controls header pin 2X+1, the odd pins.
// [R7] Pin 14 direction comes from bit 1 of the extra control location.
// [R8] Pin 14 level comes from bit 2, and bit 2 reads the pin.
// [R9] Input pins are not driven; level reads return pin or driven value. With the option fitted, bits 2..7 still read by pin_direction alone.
`timescale 1ns/1ps
`default_nettype none
module hsg_gpio (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // AXI4-Lite slave
  input wire logic [hsg_pkg::HSG_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [hsg_pkg::HSG_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [hsg_pkg::HSG_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [hsg_pkg::HSG_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Build option strap
  input wire logic EXTRA_SERIAL_FITTED,
  // Odd header pins, bit X on pin 2X+1
  input wire logic [hsg_pkg::HSG_PINS-1:0] HEADER_IO_IN,
  output logic [hsg_pkg::HSG_PINS-1:0] HEADER_IO_OUT,
  output logic [hsg_pkg::HSG_PINS-1:0] HEADER_IO_OE_N,
  // Header pin 14
  input wire logic PIN14_IN,
  output logic PIN14_OUT,
  output logic PIN14_OE_N,
  // Extra serial ports
  input wire logic EXTRA_SERIAL_A_TXD,
  input wire logic EXTRA_SERIAL_A_FRAME,
  output logic EXTRA_SERIAL_A_RXD,
  input wire logic EXTRA_SERIAL_B_TXD,
  input wire logic EXTRA_SERIAL_B_FRAME,
  output logic EXTRA_SERIAL_B_RXD
);
  import hsg_pkg::*;

  // ---------------------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_hit_level;
  logic wr_hit_dir;
  logic wr_hit_extra;

  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY = !w_held;
  // Both halves in and no response pending; AW and W may come in either order
  assign do_write = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
    end else if (S_AXI_AWVALID && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID && !w_held) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Address decode
  always_comb begin
    wr_hit_level = 1'b0;
    wr_hit_dir = 1'b0;
    wr_hit_extra = 1'b0;
    if (aw_addr == HSG_LEVEL_ADDR) begin // R3
      wr_hit_level = 1'b1;
    end else if (aw_addr == HSG_DIR_ADDR) begin // R3
      wr_hit_dir = 1'b1;
    end else if (aw_addr == HSG_EXTRA_ADDR) begin // R7
      wr_hit_extra = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= HSG_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (wr_hit_level || wr_hit_dir || wr_hit_extra) ?
                     HSG_RESP_OKAY : HSG_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0] pin_level;
  logic [7:0] pin_direction;
  logic [7:0] extra_pin_control;
  logic wr_byte0;

  // Only byte lane 0 carries register data
  assign wr_byte0 = do_write && w_strb[0];

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_level <= HSG_LEVEL_RST;
    end else if (wr_byte0 && wr_hit_level) begin
      pin_level <= w_data[7:0]; // R4
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_direction <= HSG_DIR_RST;
    end else if (wr_byte0 && wr_hit_dir) begin
      pin_direction <= w_data[7:0]; // R5
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      extra_pin_control <= HSG_EXTRA_RST;
    end else if (wr_byte0 && wr_hit_extra) begin
      extra_pin_control <= w_data[7:0]; // R7 R8
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------------------
  logic [7:0] serial_out;
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe_n;
  logic [7:0] level_view;

  always_comb begin
    serial_out = 8'h00;
    serial_out[HSG_A_TXD_BIT] = EXTRA_SERIAL_A_TXD;
    serial_out[HSG_B_TXD_BIT] = EXTRA_SERIAL_B_TXD;
    serial_out[HSG_A_FRAME_BIT] = EXTRA_SERIAL_A_FRAME;
    serial_out[HSG_B_FRAME_BIT] = EXTRA_SERIAL_B_FRAME;
  end

  genvar gi;
  generate
    for (gi = 0; gi < HSG_PINS; gi++) begin : g_pin
      // Bit gi sits on header pin 2*gi+1
      always_comb begin
        if (EXTRA_SERIAL_FITTED && HSG_SERIAL_MASK[gi]) begin
          next_pin_out[gi] = serial_out[gi]; // R2
          next_pin_oe_n[gi] = !HSG_SERIAL_OUT_MASK[gi]; // R2
        end else begin
          next_pin_out[gi] = pin_level[gi]; // R1 R4 R6
          next_pin_oe_n[gi] = !pin_direction[gi]; // R5 R9
        end
        level_view[gi] = pin_direction[gi] ? pin_level[gi] : HEADER_IO_IN[gi]; // R9
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      HEADER_IO_OUT <= 8'h00;
      HEADER_IO_OE_N <= 8'hFF;
    end else begin
      HEADER_IO_OUT <= next_pin_out;
      HEADER_IO_OE_N <= next_pin_oe_n;
    end
  end

  // Receive lines idle high when the option is off
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      EXTRA_SERIAL_A_RXD <= 1'b1;
      EXTRA_SERIAL_B_RXD <= 1'b1;
    end else begin
      EXTRA_SERIAL_A_RXD <= EXTRA_SERIAL_FITTED ? HEADER_IO_IN[HSG_A_RXD_BIT] : 1'b1; // R2
      EXTRA_SERIAL_B_RXD <= EXTRA_SERIAL_FITTED ? HEADER_IO_IN[HSG_B_RXD_BIT] : 1'b1; // R2
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PIN14_OUT <= 1'b0;
      PIN14_OE_N <= 1'b1;
    end else begin
      PIN14_OUT <= extra_pin_control[HSG_EXTRA_DATA_BIT]; // R8
      PIN14_OE_N <= !extra_pin_control[HSG_EXTRA_DIR_BIT]; // R7
    end
  end

  // ---------------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------------
  logic [7:0] next_rbyte;
  logic next_rhit;
  logic [7:0] extra_view;

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_comb begin
    extra_view = extra_pin_control;
    // Data bit reports the pin level while pin 14 is an input
    if (!extra_pin_control[HSG_EXTRA_DIR_BIT]) begin
      extra_view[HSG_EXTRA_DATA_BIT] = PIN14_IN; // R8
    end
  end

  always_comb begin
    next_rbyte = 8'h00;
    next_rhit = 1'b1;
    if (S_AXI_ARADDR == HSG_LEVEL_ADDR) begin // R3
      next_rbyte = level_view; // R9
    end else if (S_AXI_ARADDR == HSG_DIR_ADDR) begin // R3
      next_rbyte = pin_direction;
    end else if (S_AXI_ARADDR == HSG_EXTRA_ADDR) begin
      next_rbyte = extra_view;
    end else begin
      next_rhit = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= HSG_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {24'h00_0000, next_rbyte};
      S_AXI_RRESP <= next_rhit ? HSG_RESP_OKAY : HSG_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence write_level_s;
    do_write && w_strb[0] && (aw_addr == HSG_LEVEL_ADDR);
  endsequence

  sequence write_dir_s;
    do_write && w_strb[0] && (aw_addr == HSG_DIR_ADDR);
  endsequence

  write_resp_a: assert property (do_write |=> S_AXI_BVALID) // R3
    else $error("write without response");

  unmapped_err_a: assert property (do_write && !wr_hit_level && !wr_hit_dir // R3
    && !wr_hit_extra |=> S_AXI_BRESP == HSG_RESP_SLVERR)
    else $error("unmapped write not refused");

  // Ties the pins to the written word, so a lost write is caught too
  level_drive_a: assert property (write_level_s ##1 !EXTRA_SERIAL_FITTED // R4
    |=> HEADER_IO_OUT == $past(w_data[7:0], 2))
    else $error("level not driven");

  dir_drive_a: assert property (write_dir_s ##1 !EXTRA_SERIAL_FITTED // R5
    |=> HEADER_IO_OE_N == ~$past(w_data[7:0], 2))
    else $error("direction not applied");

  plain_gpio_a: assert property (!EXTRA_SERIAL_FITTED // R1
    |=> HEADER_IO_OUT == $past(pin_level) && HEADER_IO_OE_N == ~$past(pin_direction))
    else $error("plain pin mismatch");

  serial_pins_a: assert property (EXTRA_SERIAL_FITTED // R2
    |=> HEADER_IO_OUT[HSG_A_TXD_BIT] == $past(EXTRA_SERIAL_A_TXD)
        && HEADER_IO_OE_N[HSG_A_RXD_BIT]
        && EXTRA_SERIAL_B_RXD == $past(HEADER_IO_IN[HSG_B_RXD_BIT]))
    else $error("serial pins wrong");

  bit_map_a: assert property (!EXTRA_SERIAL_FITTED && pin_direction[7] && !pin_level[7] // R6
    |=> !HEADER_IO_OE_N[7] && !HEADER_IO_OUT[7])
    else $error("bit 7 mapping wrong");

  input_undriven_a: assert property (!EXTRA_SERIAL_FITTED && !pin_direction[0] // R9
    |=> HEADER_IO_OE_N[0])
    else $error("input pin driven");

  level_read_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY // R9
    && S_AXI_ARADDR == HSG_LEVEL_ADDR |=> S_AXI_RDATA[7:0] == $past(level_view))
    else $error("level readback wrong");

  pin14_dir_a: assert property (extra_pin_control[HSG_EXTRA_DIR_BIT] // R7
    |=> !PIN14_OE_N)
    else $error("pin 14 not driven");

  pin14_data_a: assert property (extra_pin_control[HSG_EXTRA_DATA_BIT] ##1 // R8
    extra_pin_control[HSG_EXTRA_DATA_BIT] |-> PIN14_OUT)
    else $error("pin 14 level wrong");

endmodule : hsg_gpio
`default_nettype wire

// ### testbench/hsg_pins_model.sv
// Model of the external devices wired to the header pins
`timescale 1ns/1ps
`default_nettype none
module hsg_pins_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] drv_out,
  input wire logic [W-1:0] drv_oe_n,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin_lvl
);
  // Device drives when its enable is low; otherwise the far device sets the level
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_lvl[i] = drv_oe_n[i] ? ext_val[i] : drv_out[i];
    end
  end
endmodule : hsg_pins_model
`default_nettype wire

// ### testbench/header_simple_gpio_bench.sv
// Testbench: header simple GPIO registers, pins and serial option
`timescale 1ns/1ps
`default_nettype none
module header_simple_gpio_bench;
  import hsg_pkg::*;
  logic ref_clk = 0, sys_rst = 1;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] wstrb = 4'hF;
  logic fitted = 0, a_txd = 0, a_frm = 0, b_txd = 0, b_frm = 0, a_rxd, b_rxd;
  logic [7:0] ext = 0, hout, hoe_n, hin;
  logic p14_ext = 0, p14_out, p14_oe_n, p14_in;
  // Rows: direction, level, far-side drive, expected level read
  logic [31:0] rows [5] = '{32'hFFA500A5, 32'h00FF3C3C, 32'hF05A0F5F, 32'h0F81C3C1,
    32'h0101FEFF};
  int bad_count = 0, n_compared = 0;

  initial forever #50 ref_clk = ~ref_clk;

  hsg_gpio dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .EXTRA_SERIAL_FITTED(fitted),
    .HEADER_IO_IN(hin), .HEADER_IO_OUT(hout), .HEADER_IO_OE_N(hoe_n), .PIN14_IN(p14_in),
    .PIN14_OUT(p14_out), .PIN14_OE_N(p14_oe_n), .EXTRA_SERIAL_A_TXD(a_txd),
    .EXTRA_SERIAL_A_FRAME(a_frm), .EXTRA_SERIAL_A_RXD(a_rxd), .EXTRA_SERIAL_B_TXD(b_txd),
    .EXTRA_SERIAL_B_FRAME(b_frm), .EXTRA_SERIAL_B_RXD(b_rxd));
  hsg_pins_model #(.W(8)) pins (.drv_out(hout), .drv_oe_n(hoe_n), .ext_val(ext),
    .pin_lvl(hin));
  hsg_pins_model #(.W(1)) pin14 (.drv_out(p14_out), .drv_oe_n(p14_oe_n), .ext_val(p14_ext),
    .pin_lvl(p14_in));

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask : chk

  task automatic guard(inout int n);
    n++;
    if (n > 200) begin
      bad_count++;
      test_done();
    end
  endtask : guard

  // ---------------------------------------------------------------------------
  // AXI4-Lite master
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      guard(n);
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    // Pins follow the register one edge later; settled by this point
    @(negedge ref_clk);
  endtask : wr

  task automatic rdr(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      guard(n);
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rdr

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    chk("oe_n rst", hoe_n, 8'hFF);
    chk("p14 oe_n rst", p14_oe_n, 1'b1);
    chk("rxd rst", {a_rxd, b_rxd}, 2'b11);
    chk("ready rst", {awready, wready, arready}, 3'b111);
    foreach (rows[i]) begin
      @(posedge ref_clk);
      ext <= rows[i][15:8];
      wr(HSG_LEVEL_ADDR, rows[i][23:16]);
      wr(HSG_DIR_ADDR, rows[i][31:24]);
      chk("wr resp", resp, HSG_RESP_OKAY);
      chk("oe_n", hoe_n, 8'(~rows[i][31:24]));
      chk("out", hout & rows[i][31:24], rows[i][23:16] & rows[i][31:24]);
      rdr(HSG_LEVEL_ADDR);
      chk("level", rd, rows[i][7:0]);
      rdr(HSG_DIR_ADDR);
      chk("dir", rd, rows[i][31:24]);
    end
    // Unmapped word: error answer, no side effect
    wr(HSG_GPIO_BASE + 32'h8, 8'h00);
    chk("bad wr resp", resp, HSG_RESP_SLVERR);
    rdr(HSG_GPIO_BASE + 32'h8);
    chk("bad rd resp", resp, HSG_RESP_SLVERR);
    chk("bad rd data", rd, 32'h0);
    rdr(HSG_DIR_ADDR);
    chk("dir kept", rd, 32'h01);
    // Byte lane 0 disabled: answered, nothing stored
    @(posedge ref_clk);
    wstrb <= 4'hE;
    wr(HSG_DIR_ADDR, 8'hAA);
    chk("strb resp", resp, HSG_RESP_OKAY);
    chk("strb oe_n", hoe_n, 8'hFE);
    @(posedge ref_clk);
    wstrb <= 4'hF;
    wr(HSG_EXTRA_ADDR, 8'h06);
    chk("p14 drive", {p14_oe_n, p14_out}, 2'b01);
    @(posedge ref_clk);
    p14_ext <= 1'b1;
    wr(HSG_EXTRA_ADDR, 8'h00);
    chk("p14 input", p14_oe_n, 1'b1);
    rdr(HSG_EXTRA_ADDR);
    chk("p14 read", rd, 32'h04);
    // Serial option takes bits 2..7; bits 0 and 1 stay plain GPIO
    @(posedge ref_clk);
    fitted <= 1'b1;
    a_txd <= 1'b1;
    b_frm <= 1'b1;
    ext <= 8'h08;
    wr(HSG_DIR_ADDR, 8'hFF);
    wr(HSG_LEVEL_ADDR, 8'h03);
    chk("serial out", {hout[7:6], hout[4], hout[2]}, 4'b1001);
    chk("serial oe_n", hoe_n[5:3], 3'b101);
    chk("serial rxd", {a_rxd, b_rxd}, 2'b10);
    chk("gpio kept", {hoe_n[1:0], hout[1:0]}, 4'b0011);
    // Option dropped with reset so no serial check spans the release edge
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    fitted <= 1'b0;
    @(negedge ref_clk);
    chk("oe_n rst2", hoe_n, 8'hFF);
    chk("rxd rst2", {a_rxd, b_rxd}, 2'b11);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdr(HSG_DIR_ADDR);
    chk("dir rst2", rd, 32'h0);
    test_done();
  end
endmodule : header_simple_gpio_bench
`default_nettype wire
